/* File: toc_channels.sv */
// two capture/compare channels with buffered pair mode on a free counter
// register map, one 16-bit word per index
//   0 channel0 control: link, action, capture, irq enable
//   1 channel0 value
//   2 channel1 control: action, capture, irq enable, no link
//   3 channel1 value
//   4 status: active set, overflow, channel1 and channel0 flags
//   5 counter, read only
//   6 modulo, last count before the wrap
//   7 timer control: overflow irq enable, run
//   8..15 unmapped, read as zero, writes dropped
//
// action field in compare mode
//   none keeps the pin, toggle inverts it,
//   clear drives it low, set drives it high
// same field in capture mode picks the edge
//   clear code: rising, toggle code: falling,
//   set code: both, none: capture off
//
// counter
//   counts while run is set and the clock enable is high
//   goes to zero on the edge after it equals the modulo
//   so one overflow period is modulo plus one counts
//   overflow flag rises on that same wrap edge
//
// compare
//   match when the counter equals the active value
//   pin and flag change on the matching edge
//   at most one match per period per value,
//   unless software moves the value past the counter
//   no shadow copy in unbuffered mode: a write lands at once,
//   so a value written just behind the counter is missed
//   until the next period, up to two periods of odd pulses
//
// capture
//   edge seen against the previous pin sample
//   pins are taken as synchronous; an async source needs
//   a synchroniser outside this block
//   capture wins over a software write in the same cycle
//
// flags
//   write one to clear bits 0..2 of the status word
//   a hardware set in the clearing cycle wins,
//   so an event is never lost to a late clear
//   irq outputs are levels: flag and enable
//
// buffered pair
//   link bit in channel0 control joins the two channels
//   channel0 pin then follows whichever value set is active
//   active set starts at channel0 when the link is made
//   and moves only on a wrap, to the set written last
//   a write to the active set acts at once, as unbuffered
//   channel1 control is ignored and its pin is handed
//   to the general-purpose drive inputs
//   status bit 3 tells software which set is active,
//   so it can aim the next write at the other one
//
// software timing hints for unbuffered channels
//   lower a value from the compare irq handler,
//   raise it from the overflow irq handler;
//   raising it from the compare handler may give
//   a second match in the same period
//
// clock enable
//   low freezes counter, flags, registers and read data;
//   bus strobes seen while it is low are dropped
//
// limitations
//   no prescaler and no pwm; the counter steps once
//   per enabled clock
//   no input filter; a one-cycle glitch on a pin in
//   capture mode is taken as a real edge
//   counter reads are not latched across bytes,
//   the full word comes in one access
//
// Local design decisions: the register offsets and strobed register access.
`include "toc_consts.svh"

module toc_channels #(
  parameter int CNT_W = `TOC_CNT_W
) (
  // clock, reset, enable
  input  wire logic                    core_clk,
  input  wire logic                    srst,
  input  wire logic                    clk_en,
  // register port
  input  wire logic [`TOC_ADDR_W-1:0]  reg_addr,
  input  wire logic [`TOC_DATA_W-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [`TOC_DATA_W-1:0]  reg_rdata,
  // channel pins, output enable low while driving
  input  wire logic                    channel0_pin_i,
  output logic                         channel0_pin_o,
  output logic                         channel0_pin_oe_n,
  input  wire logic                    channel1_pin_i,
  output logic                         channel1_pin_o,
  output logic                         channel1_pin_oe_n,
  // general-purpose drive of channel1 pin while linked
  input  wire logic                    gpio1_out,
  input  wire logic                    gpio1_oe_n,
  // interrupt request levels
  output logic                         irq_channel,
  output logic                         irq_overflow
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] mod_q;
  logic [4:0]       ctrl_q [2];
  logic [CNT_W-1:0] val_q  [2];
  logic [1:0]       chf_q;
  logic             tof_q;
  logic             run_q;
  logic             toie_q;
  logic             act_set_q;   // register set driving the pair
  logic             last_wr_q;   // set written most recently
  logic [1:0]       pin_q;
  logic [1:0]       in_q;
  logic             wrap;
  logic             linked;
  logic [1:0]       match;
  logic [1:0]       cap_ev;
  logic [1:0]       val_wr;
  logic             stat_wr;
  logic [`TOC_DATA_W-1:0] rd_mux;

  assign linked  = ctrl_q[0][`TOC_C_LINK];
  assign wrap    = clk_en && run_q && (cnt_q == mod_q);
  assign stat_wr = reg_wr && (reg_addr == `TOC_A_STAT);
  assign val_wr[0] = reg_wr && (reg_addr == `TOC_A_VAL0);
  assign val_wr[1] = reg_wr && (reg_addr == `TOC_A_VAL1);

  // free-running counter, wraps at the modulo value
  always_ff @(posedge core_clk)
  begin
    if (srst)
      cnt_q <= '0;
    else if (clk_en && run_q)
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
  end

  // modulo and run control
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      mod_q  <= CNT_W'(`TOC_MOD_RST);
      run_q  <= 1'b0;
      toie_q <= 1'b0;
    end
    else if (clk_en && reg_wr)
    begin
      if (reg_addr == `TOC_A_MOD)
        mod_q <= reg_wdata[CNT_W-1:0];
      if (reg_addr == `TOC_A_TCTRL)
      begin
        run_q  <= reg_wdata[`TOC_T_RUN];
        toie_q <= reg_wdata[`TOC_T_TOIE];
      end
    end
  end

  // pin input history for capture edge detection
  always_ff @(posedge core_clk)
  begin
    if (srst)
      in_q <= 2'b00;
    else if (clk_en)
      in_q <= {channel1_pin_i, channel0_pin_i};
  end

  // buffered pair bookkeeping: swap only at wrap
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      act_set_q <= 1'b0;
      last_wr_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!linked)
      begin
        act_set_q <= 1'b0;
        last_wr_q <= 1'b0;
      end
      else
      begin
        if (val_wr[1])
          last_wr_q <= 1'b1;
        else if (val_wr[0])
          last_wr_q <= 1'b0;
        if (wrap)
          act_set_q <= val_wr[1] ? 1'b1 :
                       val_wr[0] ? 1'b0 : last_wr_q;
      end
    end
  end

  // per-channel compare, capture, value and control
  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    logic [4:0]       cfg;
    logic [CNT_W-1:0] cmp_val;
    logic             rise;
    logic             fall;
    logic             edge_hit;
    toc_pkg::toc_act_t act;

    // channel1 control is ignored while paired
    assign cfg     = (i == 1 && linked) ? `TOC_CTRL_RST : ctrl_q[i];
    assign act     = toc_pkg::toc_act_t'(cfg[`TOC_C_ACT_HI:`TOC_C_ACT_LO]);
    assign cmp_val = (i == 0 && linked) ? val_q[act_set_q] : val_q[i];
    assign rise    = (i == 0 ? channel0_pin_i : channel1_pin_i) && !in_q[i];
    assign fall    = !(i == 0 ? channel0_pin_i : channel1_pin_i) && in_q[i];
    assign match[i]  = clk_en && run_q && !cfg[`TOC_C_CAP] &&
                       (act != toc_pkg::TOC_ACT_NONE) &&
                       (cnt_q == cmp_val);

    // capture edge select: rising, falling or both
    always_comb
    begin
      edge_hit = 1'b0;
      case (act)
        toc_pkg::TOC_ACT_CLEAR:  edge_hit = rise;
        toc_pkg::TOC_ACT_TOGGLE: edge_hit = fall;
        toc_pkg::TOC_ACT_SET:    edge_hit = rise || fall;
        default:                 edge_hit = 1'b0;
      endcase
    end
    assign cap_ev[i] = clk_en && cfg[`TOC_C_CAP] && edge_hit;

    // value register: software write or capture, capture wins
    always_ff @(posedge core_clk)
    begin
      if (srst)
        val_q[i] <= '0;
      else if (cap_ev[i])
        val_q[i] <= cnt_q;
      else if (clk_en && val_wr[i])
        val_q[i] <= reg_wdata[CNT_W-1:0];
    end

    // control register
    always_ff @(posedge core_clk)
    begin
      if (srst)
        ctrl_q[i] <= `TOC_CTRL_RST;
      else if (clk_en && reg_wr &&
               reg_addr == (i == 0 ? `TOC_A_CTRL0 : `TOC_A_CTRL1))
        ctrl_q[i] <= (i == 0) ? reg_wdata[4:0]
                              : {1'b0, reg_wdata[3:0]};
    end

    // pin action on match; no resync, so a late write misses a period
    always_ff @(posedge core_clk)
    begin
      if (srst)
        pin_q[i] <= 1'b0;
      else if (match[i])
      begin
        case (act)
          toc_pkg::TOC_ACT_SET:    pin_q[i] <= 1'b1;
          toc_pkg::TOC_ACT_CLEAR:  pin_q[i] <= 1'b0;
          toc_pkg::TOC_ACT_TOGGLE: pin_q[i] <= !pin_q[i];
          default:                 pin_q[i] <= pin_q[i];
        endcase
      end
    end

    // event flag, set wins over a clear in the same cycle
    always_ff @(posedge core_clk)
    begin
      if (srst)
        chf_q[i] <= 1'b0;
      else if (match[i] || cap_ev[i])
        chf_q[i] <= 1'b1;
      else if (clk_en && stat_wr && reg_wdata[i])
        chf_q[i] <= 1'b0;
    end
  end

  // overflow flag, set wins over clear
  always_ff @(posedge core_clk)
  begin
    if (srst)
      tof_q <= 1'b0;
    else if (wrap)
      tof_q <= 1'b1;
    else if (clk_en && stat_wr && reg_wdata[`TOC_S_TOF])
      tof_q <= 1'b0;
  end

  // interrupt requests gated by per-channel enables and the overflow enable
  assign irq_channel  = (chf_q[0] && ctrl_q[0][`TOC_C_IE]) ||
                        (chf_q[1] && !linked &&
                         ctrl_q[1][`TOC_C_IE]);
  assign irq_overflow = tof_q && toie_q;

  // pin drivers; channel1 goes to GPIO when paired
  assign channel0_pin_o    = pin_q[0];
  assign channel0_pin_oe_n = ctrl_q[0][`TOC_C_CAP];
  assign channel1_pin_o    = linked ? gpio1_out : pin_q[1];
  assign channel1_pin_oe_n = linked ? gpio1_oe_n : ctrl_q[1][`TOC_C_CAP];

  // read multiplexer; unmapped indices read as zero
  always_comb
  begin
    rd_mux = '0;
    case (reg_addr)
      `TOC_A_CTRL0: rd_mux = 16'(ctrl_q[0]);
      `TOC_A_VAL0:  rd_mux = 16'(val_q[0]);
      `TOC_A_CTRL1: rd_mux = 16'(ctrl_q[1]);
      `TOC_A_VAL1:  rd_mux = 16'(val_q[1]);
      `TOC_A_STAT:  rd_mux = 16'({act_set_q, tof_q, chf_q});
      `TOC_A_COUNT: rd_mux = 16'(cnt_q);
      `TOC_A_MOD:   rd_mux = 16'(mod_q);
      `TOC_A_TCTRL: rd_mux = 16'({toie_q, run_q});
      default:      rd_mux = '0;
    endcase
  end

  // read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk)
  begin
    if (srst)
      reg_rdata <= '0;
    else if (clk_en)
      reg_rdata <= reg_rd ? rd_mux : '0;
  end

endmodule

/* File: toc_consts.svh */
// register offsets, field positions and reset values of the timer channels
`ifndef TOC_CONSTS_SVH
`define TOC_CONSTS_SVH

`define TOC_CNT_W         16
`define TOC_ADDR_W        4
`define TOC_DATA_W        16
// register indices (one 16-bit word each)
`define TOC_A_CTRL0       4'h0
`define TOC_A_VAL0        4'h1
`define TOC_A_CTRL1       4'h2
`define TOC_A_VAL1        4'h3
`define TOC_A_STAT        4'h4
`define TOC_A_COUNT       4'h5
`define TOC_A_MOD         4'h6
`define TOC_A_TCTRL       4'h7
// channel control fields
`define TOC_C_IE          0
`define TOC_C_CAP         1
`define TOC_C_ACT_LO      2
`define TOC_C_ACT_HI      3
`define TOC_C_LINK        4
// status fields (write one to clear bits 0..2, active set read only)
`define TOC_S_CH0F        0
`define TOC_S_CH1F        1
`define TOC_S_TOF         2
`define TOC_S_ACTSET      3
// timer control fields
`define TOC_T_RUN         0
`define TOC_T_TOIE        1
`define TOC_CTRL_RST      5'h00
`define TOC_MOD_RST       16'hFFFF

`endif

/* File: toc_pkg.sv */
// types shared by the timer output compare channels
package toc_pkg;
  // compare pin action, also capture edge select
  typedef enum logic [1:0]
  {
    TOC_ACT_NONE   = 2'b00,
    TOC_ACT_TOGGLE = 2'b01,
    TOC_ACT_CLEAR  = 2'b10,
    TOC_ACT_SET    = 2'b11
  } toc_act_t;
endpackage

/* File: toc_channels_properties.sv */
// assertion checker for the timer capture/compare channels
module toc_channels_properties (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // pins and requests
  input wire logic        channel0_pin_o,
  input wire logic        channel0_pin_oe_n,
  input wire logic        channel1_pin_o,
  input wire logic        channel1_pin_oe_n,
  input wire logic        gpio1_out,
  input wire logic        gpio1_oe_n,
  input wire logic        irq_channel,
  input wire logic        irq_overflow
);
  logic [4:0] ctl0_q;
  logic [1:0] ctl1_q;
  logic       toie_q;

  // shadow of control bits; bench keeps the clock enable high
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ctl0_q <= 5'h00;
      ctl1_q <= 2'h0;
      toie_q <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 4'h0) ctl0_q <= reg_wdata[4:0];
      if (reg_addr == 4'h2) ctl1_q <= reg_wdata[1:0];
      if (reg_addr == 4'h7) toie_q <= reg_wdata[1];
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_rdi; !reg_rd |=> reg_rdata == 16'h0000; endproperty
  a_rdi: assert property (p_rdi) else $error("rdata not idle");
  property p_unm; reg_rd && reg_addr[3] |=> reg_rdata == 16'h0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_gp; ctl0_q[4] |-> {channel1_pin_o, channel1_pin_oe_n}
    == {gpio1_out, gpio1_oe_n}; endproperty
  a_gp: assert property (p_gp) else $error("pin1 not free");
  property p_ovf; !toie_q |-> !irq_overflow; endproperty
  a_ovf: assert property (p_ovf) else $error("tof irq leak");
  property p_chm; !ctl0_q[0] && (!ctl1_q[0] || ctl0_q[4]) |-> !irq_channel;
  endproperty
  a_chm: assert property (p_chm) else $error("channel irq");
  property p_oe0; !ctl0_q[4] |-> channel0_pin_oe_n == ctl0_q[1]; endproperty
  a_oe0: assert property (p_oe0) else $error("pin0 enable");
  property p_oe1; !ctl0_q[4] |-> channel1_pin_oe_n == ctl1_q[1]; endproperty
  a_oe1: assert property (p_oe1) else $error("pin1 enable");
  property p_hold; ctl0_q[3:2] == 2'b00 |=> $stable(channel0_pin_o); endproperty
  a_hold: assert property (p_hold) else $error("pin0 moved");
endmodule

bind toc_channels toc_channels_properties u_props (.core_clk, .srst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .channel0_pin_o,
  .channel0_pin_oe_n, .channel1_pin_o, .channel1_pin_oe_n, .gpio1_out,
  .gpio1_oe_n, .irq_channel, .irq_overflow);

/* File: tb_toc_channels.sv */
// self-checking bench of the timer capture/compare channels
module tb_toc_channels;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        srst     = 1'b1;
  logic        reg_wr   = 1'b0;
  logic        reg_rd   = 1'b0;
  logic        ch1_i    = 1'b0;
  logic        gpio_o   = 1'b0;
  logic        rd_d     = 1'b0;
  logic        e        = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] v;
  logic [31:0] lfsr     = 32'h549ABCD4;
  logic [31:0] notes[$];
  int          n_errors = 0;
  int          check_count = 0;
  int          n;
  wire  [15:0] reg_rdata;
  wire         p0, oe0, p1, oe1, irq_c, irq_o;
  toc_pkg::toc_act_t acts[3] = '{toc_pkg::TOC_ACT_SET,
    toc_pkg::TOC_ACT_CLEAR, toc_pkg::TOC_ACT_TOGGLE};

  toc_channels uut (.core_clk(core_clk), .srst(srst), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel0_pin_i(1'b0),
    .channel0_pin_o(p0), .channel0_pin_oe_n(oe0), .channel1_pin_i(ch1_i),
    .channel1_pin_o(p1), .channel1_pin_oe_n(oe1), .gpio1_out(gpio_o),
    .gpio1_oe_n(~gpio_o), .irq_channel(irq_c), .irq_overflow(irq_o));

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one step of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one bus cycle; strobes stay up until the next access or wait
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    acc(1'b1, a, d);
  endtask

  // expected value is noted with its mask before the read goes out
  task automatic rd(input logic [3:0] a, input logic [15:0] x, m);
    notes.push_back({m, x});
    acc(1'b0, a, 16'h0000);
  endtask

  // bounded wait for a request; outputs seen at the edge are settled
  task automatic wt(input logic o);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while ((o ? irq_o : irq_c) !== 1'b1 && n < 200);
    if (n == 200)
    begin
      n_errors++;
      finish_test();
    end
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge core_clk)
  begin
    rd_d <= reg_rd;
    if (rd_d && notes.size() > 0)
    begin
      chk("rdata", reg_rdata & notes[0][31:16],
          notes[0][15:0]);
      void'(notes.pop_front());
    end
  end

  initial
  begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    for (int a = 0; a < 16; a++)
      rd(a[3:0], (a == 6) ? 16'hFFFF : 16'h0000, 16'hFFFF);
    // capture while stopped at zero overwrites the preload
    wr(4'h3, 16'h1234);
    wr(4'h2, 16'h000B);
    ch1_i <= 1'b1;
    wt(1'b0);
    chk("oe1", {15'h0000, oe1}, 16'h0001);
    rd(4'h3, 16'h0000, 16'hFFFF);
    rd(4'h4, 16'h0002, 16'h0007);
    wr(4'h4, 16'h0007);
    wr(4'h2, 16'h0000);
    lfsr = lfsr_next(lfsr);
    v = {13'h0000, lfsr[2:0]} + 16'h0002;
    wr(4'h6, 16'h000F);
    wr(4'h1, v);
    rd(4'h1, v, 16'hFFFF);
    wr(4'h7, 16'h0001);
    // set, clear and toggle pin actions, each one changes the pin
    for (int i = 0; i < 3; i++)
    begin
      wr(4'h0, {12'h000, acts[i], 2'b01});
      wr(4'h4, 16'h0007);
      wt(1'b0);
      e = (acts[i] == toc_pkg::TOC_ACT_TOGGLE) ? ~e : acts[i][0];
      chk("pin0", {15'h0000, p0}, {15'h0000, e});
    end
    // wrap to wrap spacing less the clearing write cycle, counted by the second wait
    wr(4'h0, 16'h0000);
    wr(4'h7, 16'h0003);
    wr(4'h4, 16'h0004);
    wt(1'b1);
    wr(4'h4, 16'h0004);
    wt(1'b1);
    chk("period", n[15:0], 16'h000F);
    // linked pair; active set moves only at the wrap
    gpio_o <= lfsr[5];
    wr(4'h0, 16'h0014);
    wr(4'h4, 16'h0004);
    wt(1'b1);
    chk("gpio", {14'h0000, p1, oe1},
        {14'h0000, gpio_o, ~gpio_o});
    for (int i = 0; i < 2; i++)
    begin
      wr(i ? 4'h1 : 4'h3, v);
      rd(4'h4, i ? 16'h0008 : 16'h0000, 16'h0008);
      wr(4'h4, 16'h0004);
      wt(1'b1);
      rd(4'h4, i ? 16'h0000 : 16'h0008, 16'h0008);
    end
    acc(1'b1, 4'hF, 16'h0000);
    rd(4'hF, 16'h0000, 16'hFFFF);
    reg_rd <= 1'b0;
    repeat (2) @(posedge core_clk);
    finish_test();
  end
endmodule
